// file: core/nph_consts.svh
// Command codes, register offsets, field positions and timing counts for the NAND host
`ifndef NPH_CONSTS_SVH
`define NPH_CONSTS_SVH
// ---------------------------------------------------------------
// Device command codes
// ---------------------------------------------------------------
`define NPH_CMD_LOAD     8'h80
`define NPH_CMD_RCOL     8'h85
`define NPH_CMD_CONF     8'h10
`define NPH_CMD_CACHE    8'h15
`define NPH_CMD_ERASE    8'h60
`define NPH_CMD_ERCONF   8'hd0
`define NPH_CMD_ID       8'h90
`define NPH_CMD_STAT     8'h70
`define NPH_ID_STD       8'h00
`define NPH_ID_ONFI      8'h20
`define NPH_ID_STD_LAST  3'd4
`define NPH_ID_ONFI_LAST 3'd3
// ---------------------------------------------------------------
// Operation codes written to the control register
// ---------------------------------------------------------------
`define NPH_OP_PROG      3'd1
`define NPH_OP_CACHE     3'd2
`define NPH_OP_ERASE     3'd3
`define NPH_OP_ID        3'd4
`define NPH_OP_STAT      3'd5
// ---------------------------------------------------------------
// Register offsets and control bits
// ---------------------------------------------------------------
`define NPH_OFF_CTRL     8'h00
`define NPH_OFF_COL      8'h04
`define NPH_OFF_ROW      8'h08
`define NPH_OFF_LEN      8'h0c
`define NPH_OFF_RCOL     8'h10
`define NPH_OFF_BUF      8'h14
`define NPH_OFF_STATUS   8'h18
`define NPH_OFF_ID0      8'h1c
`define NPH_OFF_ID4      8'h20
`define NPH_CTRL_LAST    3
`define NPH_CTRL_REWIND  4
`define NPH_CTRL_WP      5
`define NPH_ST_CLR_ERR   2
`define NPH_ST_CLR_ORD   3
`define NPH_RCOL_EN      16
// ---------------------------------------------------------------
// Geometry and timing
// ---------------------------------------------------------------
`define NPH_PAGE_BYTES   2112
`define NPH_PART_MAX     3'd4
`define NPH_LAST_ADDR    3'd4
`define NPH_FIRST_ROW    3'd2
`define NPH_CLK_NS       40
`define NPH_PHASE_NS     160
`define NPH_DIV          (`NPH_PHASE_NS / `NPH_CLK_NS)
`define NPH_TWB_NS       100
`define NPH_TWB_CYC      ((`NPH_TWB_NS + `NPH_CLK_NS - 1) / `NPH_CLK_NS)
`define NPH_SYNC_CYC     3
`endif

// file: core/nph_pkg.sv
// Types shared by the NAND host sequencer
package nph_pkg;
  typedef enum logic [3:0] {
    NPH_IDLE, NPH_CMD1, NPH_ADDR, NPH_DATA, NPH_C85, NPH_RCOL,
    NPH_CMD2, NPH_WB, NPH_BUSY, NPH_READ
  } nph_state_type;
endpackage

// file: core/nph_buf.sv
// Page staging memory with a registered read port
`timescale 1ns/1ps
module nph_buf #(
  parameter int DEPTH = 2112,
  parameter int AW    = 12
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  // Plain synchronous RAM; no reset so it maps to block memory
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// file: core/nph_host.sv
// AHB-Lite controlled host sequencer for NAND program, erase, ID and status
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "nph_consts.svh"
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module nph_host #(
  parameter int DEPTH = `NPH_PAGE_BYTES,
  parameter int AW    = 12
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             re_n,
  output logic             wp_n,
  input  wire logic [7:0]  io_in,
  output logic      [7:0]  io_out,
  output logic             io_oe,
  input  wire logic        rb_n_in
);
  localparam int         TWB_WAIT = `NPH_TWB_CYC + `NPH_SYNC_CYC;
  localparam logic [3:0] WB_LOAD  = 4'(TWB_WAIT - 1);

  nph_pkg::nph_state_type st_r, nx_st;
  logic [2:0]    rb_q;
  logic          rdy_r;
  logic [7:0]    io_q0, io_q1, io_q2, io_s_r, io_s_nxt;
  logic [1:0]    div_r;
  logic          tick, ph_r;
  logic [2:0]    acnt_r, nx_acnt, rcnt_r, op_r, rlast;
  logic [AW-1:0] dcnt_r, len_r, split_r, bwp_r;
  logic [3:0]    wcnt_r;
  logic [11:0]   col_r, rcol_r;
  logic [18:0]   row_r;
  logic          rcol_en_r, split_done_r, last_r, err_r, ord_err_r, have_r;
  logic [39:0]   id_r;
  logic [7:0]    stat_r, nx_io, conf, buf_rd;
  logic [12:0]   last_blk_r;
  logic [5:0]    last_page_r;
  logic [2:0]    part_r;
  logic          nx_cle, nx_ale, dp_wr_r;
  logic [7:0]    dp_addr_r;
  logic          wr_ctrl, is_prog, same_blk, bad_order, bad_part, bad_id, op_ok, start;
  logic [2:0]    new_op;

  // ---------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_q  <= 3'h0;
      rdy_r <= 1'b0;
    end else begin
      rb_q <= {rb_q[1:0], rb_n_in};
      if (rb_q[1] == rb_q[2]) rdy_r <= rb_q[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_q0  <= 8'h00;
      io_q1  <= 8'h00;
      io_q2  <= 8'h00;
      io_s_r <= 8'h00;
    end else begin
      io_q0 <= io_in;
      io_q1 <= io_q0;
      io_q2 <= io_q1;
      io_s_r <= io_s_nxt;
    end
  end

  // Settled bus value; readers take this so a byte is not one clock stale
  assign io_s_nxt = (io_q1 == io_q2) ? io_q2 : io_s_r;

  // Strobe phase divider; free running, so the first phase after a start can be as short as one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_r <= 2'h0;
    else        div_r <= (div_r == 2'(`NPH_DIV - 1)) ? 2'h0 : div_r + 2'h1;
  end
  assign tick = (div_r == 2'(`NPH_DIV - 1));

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr_r <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        dp_addr_r <= haddr[7:0];
        case (haddr[7:0])
          `NPH_OFF_COL:    hrdata <= {20'h0, col_r};
          `NPH_OFF_ROW:    hrdata <= {13'h0, row_r};
          `NPH_OFF_LEN:    hrdata <= {4'h0, 12'(split_r), 4'h0, 12'(len_r)};
          `NPH_OFF_RCOL:   hrdata <= {15'h0, rcol_en_r, 4'h0, rcol_r};
          `NPH_OFF_STATUS: hrdata <= {15'h0, wp_n, stat_r, 1'b0, part_r, ord_err_r,
                                      err_r, rdy_r, st_r != nph_pkg::NPH_IDLE};
          `NPH_OFF_ID0:    hrdata <= id_r[31:0];
          `NPH_OFF_ID4:    hrdata <= {24'h0, id_r[39:32]};
          default:         hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Start checks: device readiness and page ordering guard
  assign wr_ctrl   = dp_wr_r && dp_addr_r == `NPH_OFF_CTRL;
  assign new_op    = hwdata[2:0];
  assign op_ok     = new_op >= `NPH_OP_PROG && new_op <= `NPH_OP_STAT;
  assign is_prog   = new_op == `NPH_OP_PROG || new_op == `NPH_OP_CACHE;
  assign same_blk  = have_r && row_r[18:6] == last_blk_r;
  assign bad_order = is_prog && same_blk && row_r[5:0] < last_page_r;
  assign bad_part  = is_prog && same_blk && row_r[5:0] == last_page_r
                     && part_r == `NPH_PART_MAX;
  assign bad_id    = new_op == `NPH_OP_ID && col_r[7:0] != `NPH_ID_STD
                     && col_r[7:0] != `NPH_ID_ONFI;
  // Busy device only gets status reads, and cache sequences wait for cache ready
  assign start     = wr_ctrl && st_r == nph_pkg::NPH_IDLE && op_ok
                     && (new_op == `NPH_OP_STAT || rdy_r)
                     && !bad_order && !bad_part && !bad_id;

  // Software registers and sticky refusal flags; a new refusal beats a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= 12'h0; row_r <= 19'h0; len_r <= '0; split_r <= '0;
      rcol_r <= 12'h0; rcol_en_r <= 1'b0; bwp_r <= '0; wp_n <= 1'b0;
      err_r <= 1'b0; ord_err_r <= 1'b0;
    end else begin
      if (dp_wr_r) begin
        case (dp_addr_r)
          `NPH_OFF_COL: col_r <= hwdata[11:0];
          `NPH_OFF_ROW: row_r <= hwdata[18:0];
          `NPH_OFF_LEN: begin
            len_r   <= AW'(hwdata[11:0]);
            split_r <= AW'(hwdata[27:16]);
          end
          `NPH_OFF_RCOL: begin
            rcol_r    <= hwdata[11:0];
            rcol_en_r <= hwdata[`NPH_RCOL_EN];
          end
          `NPH_OFF_BUF: if (bwp_r < AW'(DEPTH)) bwp_r <= bwp_r + 1'b1;
          `NPH_OFF_CTRL: begin
            wp_n <= hwdata[`NPH_CTRL_WP];
            if (hwdata[`NPH_CTRL_REWIND]) bwp_r <= '0;
          end
          default: ;
        endcase
      end
      if (wr_ctrl && op_ok && !start) err_r <= 1'b1;
      else if (dp_wr_r && dp_addr_r == `NPH_OFF_STATUS && hwdata[`NPH_ST_CLR_ERR]) err_r <= 1'b0;
      if (wr_ctrl && (bad_order || bad_part)) ord_err_r <= 1'b1;
      else if (dp_wr_r && dp_addr_r == `NPH_OFF_STATUS && hwdata[`NPH_ST_CLR_ORD])
        ord_err_r <= 1'b0;
    end
  end

  // Page history for the ordering and partial-program guard
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      have_r <= 1'b0; last_blk_r <= 13'h0; last_page_r <= 6'h0; part_r <= 3'h0;
    end else if (start && is_prog) begin
      have_r      <= 1'b1;
      last_blk_r  <= row_r[18:6];
      last_page_r <= row_r[5:0];
      part_r      <= (same_blk && row_r[5:0] == last_page_r) ? part_r + 3'h1 : 3'h1;
    end
  end

  nph_buf #(.DEPTH(DEPTH), .AW(AW)) u_buf (
    .clk     (clk),
    .wr_en   (dp_wr_r && dp_addr_r == `NPH_OFF_BUF && bwp_r < AW'(DEPTH)),
    .wr_addr (bwp_r),
    .wr_data (hwdata[7:0]),
    .rd_addr (dcnt_r),
    .rd_data (buf_rd)
  );

  // ---------------------------------------------------------------
  // Next bus cycle of the sequence
  // ---------------------------------------------------------------
  function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [11:0] c,
                                           input logic [18:0] r);
    case (i)
      3'd0:    addr_byte = c[7:0];
      3'd1:    addr_byte = {4'h0, c[11:8]};
      3'd2:    addr_byte = r[7:0];
      3'd3:    addr_byte = r[15:8];
      default: addr_byte = {5'h0, r[18:16]};
    endcase
  endfunction

  assign conf  = (op_r == `NPH_OP_ERASE) ? `NPH_CMD_ERCONF :
                 (op_r == `NPH_OP_CACHE && !last_r) ? `NPH_CMD_CACHE : `NPH_CMD_CONF;
  assign rlast = (op_r == `NPH_OP_STAT) ? 3'd0 :
                 (col_r[7:0] == `NPH_ID_ONFI) ? `NPH_ID_ONFI_LAST : `NPH_ID_STD_LAST;

  always_comb begin
    logic         dc_c85;
    logic         dc_end;
    dc_end  = op_r == `NPH_OP_ERASE || dcnt_r == len_r;
    dc_c85  = rcol_en_r && !split_done_r && dcnt_r == split_r;
    nx_st   = st_r;
    nx_io   = 8'h00;
    nx_cle  = 1'b0;
    nx_ale  = 1'b0;
    nx_acnt = acnt_r;
    case (st_r)
      nph_pkg::NPH_CMD1: begin
        if (op_r == `NPH_OP_STAT) nx_st = nph_pkg::NPH_READ;
        else begin
          nx_st   = nph_pkg::NPH_ADDR;
          nx_ale  = 1'b1;
          nx_acnt = (op_r == `NPH_OP_ERASE) ? `NPH_FIRST_ROW : 3'd0;
          nx_io   = (op_r == `NPH_OP_ID) ? col_r[7:0] : addr_byte(nx_acnt, col_r, row_r);
        end
      end
      nph_pkg::NPH_ADDR, nph_pkg::NPH_DATA, nph_pkg::NPH_RCOL: begin
        if (st_r == nph_pkg::NPH_ADDR && op_r == `NPH_OP_ID) nx_st = nph_pkg::NPH_READ;
        else if (st_r == nph_pkg::NPH_ADDR && acnt_r != `NPH_LAST_ADDR) begin
          nx_acnt = acnt_r + 3'd1;
          nx_ale  = 1'b1;
          nx_io   = addr_byte(nx_acnt, col_r, row_r);
        end else if (st_r == nph_pkg::NPH_RCOL && acnt_r == 3'd0) begin
          nx_acnt = 3'd1;
          nx_ale  = 1'b1;
          nx_io   = {4'h0, rcol_r[11:8]};
        end else if (dc_end) begin
          nx_st  = nph_pkg::NPH_CMD2;
          nx_cle = 1'b1;
          nx_io  = conf;
        end else if (dc_c85) begin
          nx_st  = nph_pkg::NPH_C85;
          nx_cle = 1'b1;
          nx_io  = `NPH_CMD_RCOL;
        end else begin
          nx_st = nph_pkg::NPH_DATA;
          nx_io = buf_rd;
        end
      end
      nph_pkg::NPH_C85: begin
        nx_st   = nph_pkg::NPH_RCOL;
        nx_ale  = 1'b1;
        nx_acnt = 3'd0;
        nx_io   = rcol_r[7:0];
      end
      nph_pkg::NPH_CMD2: nx_st = nph_pkg::NPH_WB;
      nph_pkg::NPH_READ: if (rcnt_r == rlast) nx_st = nph_pkg::NPH_IDLE;
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // Pin sequencer: strobe low for one phase, high for the next
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= nph_pkg::NPH_IDLE; ph_r <= 1'b0; op_r <= 3'h0; last_r <= 1'b0;
      ce_n <= 1'b1; cle <= 1'b0; ale <= 1'b0; we_n <= 1'b1; re_n <= 1'b1;
      io_out <= 8'h00; io_oe <= 1'b0; acnt_r <= 3'h0; rcnt_r <= 3'h0;
      dcnt_r <= '0; wcnt_r <= 4'h0; split_done_r <= 1'b0;
    end else begin
      case (st_r)
        nph_pkg::NPH_IDLE: if (start) begin
          op_r   <= new_op;
          last_r <= hwdata[`NPH_CTRL_LAST];
          st_r   <= nph_pkg::NPH_CMD1;
          ce_n   <= 1'b0;
          cle    <= 1'b1;
          we_n   <= 1'b0;
          io_oe  <= 1'b1;
          ph_r   <= 1'b0;
          dcnt_r <= '0;
          split_done_r <= 1'b0;
          io_out <= (new_op == `NPH_OP_ERASE) ? `NPH_CMD_ERASE :
                    (new_op == `NPH_OP_ID)    ? `NPH_CMD_ID    :
                    (new_op == `NPH_OP_STAT)  ? `NPH_CMD_STAT  : `NPH_CMD_LOAD;
        end
        nph_pkg::NPH_WB: if (wcnt_r == 4'h0) begin
          st_r <= nph_pkg::NPH_BUSY;
          ce_n <= 1'b1;
        end else wcnt_r <= wcnt_r - 4'h1;
        // Completion is seen on the busy pin; status byte is read separately
        nph_pkg::NPH_BUSY: if (rdy_r) st_r <= nph_pkg::NPH_IDLE;
        default: if (tick) begin
          ph_r <= ~ph_r;
          if (!ph_r) begin
            we_n <= 1'b1;
            re_n <= 1'b1;
            if (st_r == nph_pkg::NPH_DATA) dcnt_r <= dcnt_r + 1'b1;
          end else begin
            st_r   <= nx_st;
            cle    <= nx_cle;
            ale    <= nx_ale;
            io_out <= nx_io;
            acnt_r <= nx_acnt;
            rcnt_r <= (st_r == nph_pkg::NPH_READ) ? rcnt_r + 3'd1 : 3'd0;
            if (nx_st == nph_pkg::NPH_C85) split_done_r <= 1'b1;
            if (nx_st == nph_pkg::NPH_READ) begin
              re_n  <= 1'b0;
              io_oe <= 1'b0;
            end else if (nx_st == nph_pkg::NPH_WB) begin
              io_oe  <= 1'b0;
              wcnt_r <= WB_LOAD;
            end else if (nx_st == nph_pkg::NPH_IDLE) ce_n <= 1'b1;
            else we_n <= 1'b0;
          end
        end
      endcase
    end
  end

  // Read bytes land at the end of the low read-strobe phase; the sync chain
  // needs three clocks, so the registered copy would still hold the old byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_r   <= 40'h0;
      stat_r <= 8'h00;
    end else if (tick && !ph_r && st_r == nph_pkg::NPH_READ) begin
      if (op_r == `NPH_OP_STAT) stat_r <= io_s_nxt;
      else id_r[{rcnt_r, 3'b000} +: 8] <= io_s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ready_first;
    (st_r == nph_pkg::NPH_IDLE ##1 st_r == nph_pkg::NPH_CMD1 && io_out != `NPH_CMD_STAT)
      |-> $past(rdy_r);
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("op started on busy die");
  property p_load;
    (st_r == nph_pkg::NPH_IDLE ##1 st_r == nph_pkg::NPH_CMD1 && op_r <= `NPH_OP_CACHE)
      |-> io_out == `NPH_CMD_LOAD && cle && !we_n;
  endproperty
  a_load: assert property (p_load) else $error("program not opened by load");
  property p_conf;
    (st_r == nph_pkg::NPH_CMD2 && op_r == `NPH_OP_PROG) |-> io_out == `NPH_CMD_CONF && cle;
  endproperty
  a_conf: assert property (p_conf) else $error("program confirm wrong");
  property p_cache;
    (st_r == nph_pkg::NPH_CMD2 && op_r == `NPH_OP_CACHE)
      |-> io_out == (last_r ? `NPH_CMD_CONF : `NPH_CMD_CACHE);
  endproperty
  a_cache: assert property (p_cache) else $error("cache confirm wrong");
  property p_rcol;
    $rose(st_r == nph_pkg::NPH_C85) |-> io_out == `NPH_CMD_RCOL && cle && !ale;
  endproperty
  a_rcol: assert property (p_rcol) else $error("column change command wrong");
  property p_wait;
    $rose(st_r == nph_pkg::NPH_WB) |-> ##TWB_WAIT st_r == nph_pkg::NPH_BUSY;
  endproperty
  a_wait: assert property (p_wait) else $error("busy wait length wrong");
  property p_ce_free;
    st_r == nph_pkg::NPH_BUSY |-> ce_n && !io_oe;
  endproperty
  a_ce_free: assert property (p_ce_free) else $error("bus held while busy");
  property p_part;
    part_r <= `NPH_PART_MAX;
  endproperty
  a_part: assert property (p_part) else $error("too many partial programs");
  property p_order;
    (wr_ctrl && bad_order) |=> ord_err_r
      && !(st_r == nph_pkg::NPH_CMD1 && $past(st_r) == nph_pkg::NPH_IDLE);
  endproperty
  a_order: assert property (p_order) else $error("out of order page accepted");
  property p_five;
    ($rose(st_r == nph_pkg::NPH_DATA) && $past(st_r) == nph_pkg::NPH_ADDR)
      |-> $past(acnt_r) == `NPH_LAST_ADDR;
  endproperty
  a_five: assert property (p_five) else $error("address cycle count wrong");

  c_cache: cover property (st_r == nph_pkg::NPH_CMD2 && io_out == `NPH_CMD_CACHE);
  c_rcol:  cover property ($rose(st_r == nph_pkg::NPH_RCOL));
  c_id:    cover property (st_r == nph_pkg::NPH_READ && op_r == `NPH_OP_ID && rcnt_r == 3'd4);
endmodule

// file: test/nph_dev_model.sv
// Behavioural NAND device answering the host sequencer
`timescale 1ns/1ps
module nph_dev_model #(
  parameter int BUSY_NS = 2000
) (
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_out,
  input  wire logic       fail_next,
  output logic      [7:0] io_in,
  output logic            rb_n
);
  // ----------------------------------------------------------
  // Identity bytes; bytes 0, 1 and 4 are arbitrary values
  // ----------------------------------------------------------
  localparam logic [7:0] ID_B[5] = '{8'h3c, 8'h5e, 8'hc1, 8'h15, 8'h02};
  localparam logic [7:0] SIG_B[4] = '{8'h4f, 8'h4e, 8'h46, 8'h49};
  logic [9:0]  log_q[$];
  logic [7:0]  mem[2112];
  logic [7:0]  cmd_r = 8'h00;
  logic [11:0] col_r = 12'h000;
  logic        pf_r = 1'b0;
  logic        cpf_r = 1'b0;
  int          adr_n = 0;
  int          rd_n = 0;
  event        go_ev;
  initial rb_n = 1'b1;
  initial io_in = 8'h00;
  // Latch each write strobe; while busy only status is taken
  always @(posedge we_n) begin
    if (!ce_n) begin
      log_q.push_back({cle, ale, io_out});
      if (cle && (rb_n || io_out == 8'h70)) begin
        cmd_r = io_out;
        adr_n = 0;
        rd_n = 0;
        if (io_out inside {8'h10, 8'h15, 8'hd0}) ->go_ev;
      end else if (ale && rb_n) begin
        if (adr_n == 0 && cmd_r != 8'h60) col_r[7:0] = io_out;
        if (adr_n == 1 && cmd_r != 8'h60) col_r[11:8] = io_out[3:0];
        adr_n++;
      end else if (!cle && rb_n) begin
        mem[col_r] = io_out;
        col_r++;
      end
    end
  end
  // Own timer, so chip enable toggling cannot cut the busy span short
  always @(go_ev) begin
    rb_n = 1'b0;
    #(BUSY_NS);
    cpf_r = pf_r;
    pf_r = fail_next;
    rb_n = 1'b1;
  end
  // One byte per read strobe; a released bus shows the inverse
  always @(negedge re_n) begin
    if (!ce_n) begin
      if (cmd_r == 8'h70) io_in = {wp_n, rb_n, rb_n, 3'b000, cpf_r, pf_r};
      else if (col_r[7:0] == 8'h20) io_in = SIG_B[rd_n];
      else io_in = ID_B[rd_n];
      rd_n++;
    end
  end
  always @(posedge re_n or posedge ce_n) io_in = ~io_in;
endmodule

// file: test/tb.sv
// Self-checking bench for the NAND host sequencer
`timescale 1ns/1ps
`include "nph_consts.svh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        fail_next = 1'b0;
  logic        hreadyout, hresp, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
  logic [31:0] hrdata, q;
  logic [7:0]  io_in, io_out;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n0;
  nph_host i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .rb_n_in(rb_n));
  nph_dev_model i_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io_out(io_out), .fail_next(fail_next), .io_in(io_in), .rb_n(rb_n));
  initial forever #20 clk = ~clk;
  // ----------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Single word transfer; read data lands in q
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  // Busy flag rises the cycle after the control write, so poll after that
  task automatic idle();
    repeat (2) @(posedge clk);
    ahb(0, `NPH_OFF_STATUS, 0);
    while (q[0] !== 1'b0) ahb(0, `NPH_OFF_STATUS, 0);
  endtask
  task automatic run(input logic [31:0] w);
    n0 = i_dev.log_q.size();
    ahb(1, `NPH_OFF_CTRL, w);
    idle();
  endtask
  task automatic tail(input logic [9:0] e[]);
    chk("cycle count", n0 + e.size(), i_dev.log_q.size());
    for (int i = 0; i < e.size(); i++)
      chk("pin cycle", e[i], i_dev.log_q[n0 + i]);
  endtask
  task automatic stat(input logic [7:0] e, input logic [2:0] part);
    run(32'h25);
    chk("status byte", e, q[15:8]);
    chk("partial count", part, q[6:4]);
  endtask
  // A refused order leaves the pins quiet and raises both error flags
  task automatic refused();
    run(32'h21);
    chk("refusal flags", 32'hc, q & 32'hc);
    chk("quiet pins", n0, i_dev.log_q.size());
    ahb(1, `NPH_OFF_STATUS, 32'hc);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------
  initial begin
    #(20000 * 40);
    bad_count++;
    $display("ERROR watchdog expected done seen hang");
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    ahb(0, `NPH_OFF_STATUS, 0);
    chk("status after reset", 32'h2, q & 32'h1000f);
    chk("bus response", 32'h0, hresp);
    ahb(1, `NPH_OFF_CTRL, 32'h30);
    for (int i = 0; i < 4; i++) ahb(1, `NPH_OFF_BUF, 32'ha0 + i);
    ahb(1, `NPH_OFF_COL, 32'h40);
    ahb(1, `NPH_OFF_ROW, 32'h45);
    ahb(1, `NPH_OFF_LEN, 32'h0002_0004);
    ahb(1, `NPH_OFF_RCOL, 32'h1_0100);
    run(32'h21);
    tail('{10'h280, 10'h140, 10'h100, 10'h145, 10'h100, 10'h100, 10'h0a0, 10'h0a1,
      10'h285, 10'h100, 10'h101, 10'h0a2, 10'h0a3, 10'h210});
    chk("moved column", 32'ha3, i_dev.mem[12'h101]);
    stat(8'he0, 3'd1);
    ahb(1, `NPH_OFF_LEN, 32'h1);
    ahb(1, `NPH_OFF_RCOL, 32'h0);
    fail_next <= 1'b1;
    run(32'h21);
    stat(8'he1, 3'd2);
    fail_next <= 1'b0;
    run(32'h22);
    chk("cache confirm", 10'h215, i_dev.log_q[i_dev.log_q.size() - 1]);
    stat(8'he2, 3'd3);
    run(32'h21);
    refused();
    ahb(1, `NPH_OFF_ROW, 32'h44);
    refused();
    ahb(1, `NPH_OFF_ROW, 32'h80);
    n0 = i_dev.log_q.size();
    ahb(1, `NPH_OFF_CTRL, 32'h23);
    ahb(1, `NPH_OFF_CTRL, 32'h21);
    idle();
    chk("busy refusal", 1'b1, q[2]);
    tail('{10'h260, 10'h180, 10'h100, 10'h100, 10'h2d0});
    stat(8'he0, 3'd4);
    ahb(1, `NPH_OFF_ROW, 32'h81);
    run(32'h2a);
    chk("last cache confirm", 10'h210, i_dev.log_q[i_dev.log_q.size() - 1]);
    ahb(1, `NPH_OFF_COL, 32'h0);
    run(32'h24);
    ahb(0, `NPH_OFF_ID0, 0);
    chk("id bytes", 32'h15c15e3c, q);
    ahb(0, `NPH_OFF_ID4, 0);
    chk("id last", 32'h2, q & 32'hff);
    ahb(1, `NPH_OFF_COL, 32'h20);
    run(32'h24);
    ahb(0, `NPH_OFF_ID0, 0);
    chk("signature", 32'h49464e4f, q);
    give_verdict();
  end
endmodule
